// ==== hw/rcl_pkg.sv ====
// Package: constants and carriers for the recoverable error code logger
package rcl_pkg;
    localparam int LP_N    = 4;
    localparam int BANK_N  = 2;
    localparam int LP_IW   = 2;
    localparam int BANK_IW = 1;
    localparam int AW      = 8;
    localparam int DW      = 32;

    // Register port word addresses
    localparam logic [AW-1:0] OFF_CTRL  = 8'h00;
    localparam logic [AW-1:0] OFF_SHARE = 8'h04;
    localparam logic [AW-1:0] OFF_GSTAT = 8'h08;
    // Bank b sits in slot b+1 of address bits [7:4]
    localparam logic [3:0]    SLOT_FIRST = 4'h1;
    localparam logic [3:0]    SUB_STATUS = 4'h0;
    localparam logic [3:0]    SUB_ADDR   = 4'h4;
    localparam logic [3:0]    SUB_MISC   = 4'h8;

    // Status word bit positions
    localparam int ST_VALID = 31;
    localparam int ST_OVER  = 30;
    localparam int ST_UC    = 29;
    localparam int ST_EN    = 28;
    localparam int ST_MISC_INFO_VALID = 27;
    localparam int ST_ADDRESS_VALID = 26;
    localparam int ST_PCC   = 25;
    localparam int ST_S     = 24;
    localparam int ST_AR    = 23;
    localparam int ST_FILT  = 12;
    localparam int MISC_MODE_LO = 6;
    localparam int GSTAT_ERROR_IP_VALID_LO = LP_N;

    // Compound code pieces
    localparam logic [3:0] CODE_MEM_HI   = 4'h0;
    localparam logic [2:0] MEM_TXN_SCRUB = 3'h4;
    localparam logic [3:0] CHAN_GENERIC  = 4'hF;
    localparam logic [3:0] CODE_CACHE_HI = 4'h1;
    localparam logic [3:0] RK_EVICT      = 4'h7;
    localparam logic [3:0] RK_DATA_RD    = 4'h3;
    localparam logic [3:0] RK_INSTR_RD   = 4'h5;
    localparam logic [1:0] TT_INSTR      = 2'h0;
    localparam logic [1:0] TT_DATA       = 2'h1;
    localparam logic [1:0] TT_GENERIC    = 2'h2;
    localparam logic [1:0] LVL_0         = 2'h0;
    localparam logic [1:0] LVL_2         = 2'h2;
    localparam logic [2:0] ADDR_MODE_PHYS = 3'h2;

    // Reset values
    localparam logic                   UCR_EN_RST = 1'h1;
    localparam logic [BANK_N*LP_N-1:0] SHARE_RST  = 8'hFF;

    typedef enum logic [1:0] {
        ERR_SCRUB     = 2'h0,
        ERR_WRITEBACK = 2'h1,
        ERR_LOAD      = 2'h2,
        ERR_FETCH     = 2'h3
    } rcl_kind_e;

    typedef struct packed {
        logic               valid;
        rcl_kind_e          kind;
        logic [3:0]         chan;
        logic [DW-1:0]      addr;
        logic [5:0]         lsb;
        logic [BANK_IW-1:0] bank;
        logic [LP_IW-1:0]   lp;
        logic               cont;
        logic               error_ip_valid_nc;
    } rcl_err_s;

    typedef struct packed {
        logic          valid;
        logic          over;
        logic          uc;
        logic          en;
        logic          misc_info_valid;
        logic          address_valid;
        logic          context_corrupt_flag;
        logic          s;
        logic          ar;
        logic [15:0]   code;
        logic [DW-1:0] addr;
        logic [5:0]    lsb;
        logic [2:0]    mode;
    } rcl_bank_s;

    typedef struct packed {
        logic                         ucr_en;
        logic [BANK_N*LP_N-1:0]       share;
        logic [LP_N-1:0]              restart_ip_valid;
        logic [LP_N-1:0]              error_ip_valid;
        logic [LP_N-1:0]              mc;
        logic [LP_N-1:0]              rec;
        rcl_bank_s [BANK_N-1:0]       bank;
        logic [DW-1:0]                rdata;
    } rcl_state_s;
endpackage : rcl_pkg

// ==== hw/rcl_logger.sv ====
// Recoverable error logger: code forming, bank record, global flags, broadcast
// Summary of operation
// - scrub error code is 0xC0 plus channel
// - writeback error code is fixed 0x17A
// - writeback code uses generic type, level 2
// - data load error code is 0x134
// - instruction fetch error code is 0x150
// - filtering bit twelve always clear
// - optional-action flags set, action required clear
// - required-action flags same, action required set
// - capture address, mark address and misc valid
// - misc holds physical mode and lowest bit
// - broadcast machine check to every processor
// - record visible only to sharing processors
// - scrub/writeback: restart valid, error ip clear everywhere
// - continuable required-action: both flags set on affected
// - non-continuable: affected restart valid clear
// - unaffected observers: restart set, error ip clear
// - affected processor's bank holds the record
// - global flags separate affected from observers
// - memory code: 3-bit type, 4-bit channel
`timescale 1ns/10ps
module rcl_logger
    import rcl_pkg::*;
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire rcl_err_s           err_i,
    input  wire logic [AW-1:0]      addr_i,
    input  wire logic [DW-1:0]      wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [DW-1:0]           rdata_o,
    output logic [LP_N-1:0]         machine_check_signal_o,
    output logic [LP_N-1:0]         restart_ip_valid_o,
    output logic [LP_N-1:0]         error_ip_valid_o,
    output logic [LP_N-1:0]         lp_record_o
);

    rcl_state_s st_reg;
    rcl_state_s st_next;

    logic [3:0]         slot;
    logic [3:0]         sub;
    logic [3:0]         slot_m1;
    logic               bank_sel;
    logic [BANK_IW-1:0] bidx;
    logic               hit;
    logic               req_act;
    rcl_bank_s          nb;

    assign slot     = addr_i[7:4];
    assign sub      = addr_i[3:0];
    assign slot_m1  = slot - SLOT_FIRST;
    assign bank_sel = (slot >= SLOT_FIRST) && (slot_m1 < 4'(BANK_N));
    assign bidx     = slot_m1[BANK_IW-1:0];
    // Without recoverable support enabled, events are dropped whole
    assign hit      = err_i.valid && st_reg.ucr_en;
    assign req_act  = (err_i.kind == ERR_LOAD) || (err_i.kind == ERR_FETCH);

    function automatic logic [15:0] arch_code(input rcl_kind_e k, input logic [3:0] ch);
        logic [15:0] c;
        c = '0;
        case (k)
            ERR_SCRUB:     c = {4'h0, CODE_MEM_HI, 1'b1, MEM_TXN_SCRUB, ch};
            ERR_WRITEBACK: c = {4'h0, CODE_CACHE_HI, RK_EVICT, TT_GENERIC, LVL_2};
            ERR_LOAD:      c = {4'h0, CODE_CACHE_HI, RK_DATA_RD, TT_DATA, LVL_0};
            ERR_FETCH:     c = {4'h0, CODE_CACHE_HI, RK_INSTR_RD, TT_INSTR, LVL_0};
            default:       c = '0;
        endcase
        c[ST_FILT] = 1'b0;
        return c;
    endfunction : arch_code

    function automatic logic [DW-1:0] status_word(input rcl_bank_s b);
        logic [DW-1:0] w;
        w = '0;
        w[15:0]     = b.code;
        w[ST_VALID] = b.valid;
        w[ST_OVER]  = b.over;
        w[ST_UC]    = b.uc;
        w[ST_EN]    = b.en;
        w[ST_MISC_INFO_VALID] = b.misc_info_valid;
        w[ST_ADDRESS_VALID] = b.address_valid;
        w[ST_PCC]   = b.context_corrupt_flag;
        w[ST_S]     = b.s;
        w[ST_AR]    = b.ar;
        return w;
    endfunction : status_word

    always_comb begin
        nb       = '0;
        nb.valid = 1'b1;
        nb.uc    = 1'b1;
        nb.en    = 1'b1;
        nb.s     = 1'b1;
        nb.over  = 1'b0;
        nb.context_corrupt_flag   = 1'b0;
        nb.ar    = req_act;
        nb.misc_info_valid = 1'b1;
        nb.address_valid = 1'b1;
        nb.addr  = err_i.addr;
        nb.code  = arch_code(err_i.kind, err_i.chan);
        nb.lsb   = err_i.lsb;
        nb.mode  = ADDR_MODE_PHYS;
    end

    always_comb begin
        st_next       = st_reg;
        st_next.mc    = '0;
        st_next.rdata = '0;

        // Software side first so a same-cycle event overrides it
        if (wr_i) begin
            case (addr_i)
                OFF_CTRL:  st_next.ucr_en = wdata_i[0];
                OFF_SHARE: st_next.share  = wdata_i[BANK_N*LP_N-1:0];
                OFF_GSTAT: begin
                    st_next.restart_ip_valid = wdata_i[LP_N-1:0];
                    st_next.error_ip_valid = wdata_i[GSTAT_ERROR_IP_VALID_LO +: LP_N];
                end
                default: begin
                    // Any write to a bank status wipes that record
                    if (bank_sel && sub == SUB_STATUS) begin
                        st_next.bank[bidx] = '0;
                    end
                end
            endcase
        end

        // Record, flags and broadcast all land on one edge
        if (hit) begin
            st_next.bank[err_i.bank] = nb;
            st_next.mc = '1;
            for (int lp = 0; lp < LP_N; lp++) begin
                if (req_act && err_i.lp == LP_IW'(lp)) begin
                    st_next.restart_ip_valid[lp] = err_i.cont;
                    st_next.error_ip_valid[lp] = err_i.cont | err_i.error_ip_valid_nc;
                end else begin
                    st_next.restart_ip_valid[lp] = 1'b1;
                    st_next.error_ip_valid[lp] = 1'b0;
                end
            end
        end

        for (int lp = 0; lp < LP_N; lp++) begin
            st_next.rec[lp] = 1'b0;
            for (int b = 0; b < BANK_N; b++) begin
                if (st_next.bank[b].valid && st_next.share[b*LP_N + lp]) begin
                    st_next.rec[lp] = 1'b1;
                end
            end
        end

        if (rd_i) begin
            case (addr_i)
                OFF_CTRL:  st_next.rdata[0] = st_reg.ucr_en;
                OFF_SHARE: st_next.rdata[BANK_N*LP_N-1:0] = st_reg.share;
                OFF_GSTAT: begin
                    st_next.rdata[LP_N-1:0] = st_reg.restart_ip_valid;
                    st_next.rdata[GSTAT_ERROR_IP_VALID_LO +: LP_N] = st_reg.error_ip_valid;
                end
                default: begin
                    // Unmapped addresses read as zero
                    if (bank_sel) begin
                        case (sub)
                            SUB_STATUS: st_next.rdata = status_word(st_reg.bank[bidx]);
                            SUB_ADDR:   st_next.rdata = st_reg.bank[bidx].addr;
                            SUB_MISC: begin
                                st_next.rdata[5:0] = st_reg.bank[bidx].lsb;
                                st_next.rdata[MISC_MODE_LO +: 3] = st_reg.bank[bidx].mode;
                            end
                            default:    st_next.rdata = '0;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg        <= '0;
            st_reg.ucr_en <= UCR_EN_RST;
            st_reg.share  <= SHARE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o                = st_reg.rdata;
    assign machine_check_signal_o = st_reg.mc;
    assign restart_ip_valid_o     = st_reg.restart_ip_valid;
    assign error_ip_valid_o       = st_reg.error_ip_valid;
    assign lp_record_o            = st_reg.rec;

    // Assertion helpers: the event as taken one edge earlier
    rcl_err_s          err_q;
    logic              hit_q;
    logic              req_q;
    logic [BANK_N-1:0] bank_v;
    rcl_bank_s         lb;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_q <= '0;
            hit_q <= 1'b0;
        end else begin
            err_q <= err_i;
            hit_q <= hit;
        end
    end

    assign lb    = st_reg.bank[err_q.bank];
    assign req_q = (err_q.kind == ERR_LOAD) || (err_q.kind == ERR_FETCH);

    // Which banks hold a live record right now
    for (genvar g = 0; g < BANK_N; g++) begin : g_bank_v
        assign bank_v[g] = st_reg.bank[g].valid;
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    property p_scrub_code;
        hit_q && err_q.kind == ERR_SCRUB |-> lb.code == {8'h00, 4'hC, err_q.chan};
    endproperty
    a_scrub_code: assert property (p_scrub_code) else $error("scrub code wrong");

    property p_wb_code;
        hit_q && err_q.kind == ERR_WRITEBACK |-> lb.code == 16'h017A && lb.code[3:0] == 4'hA;
    endproperty
    a_wb_code: assert property (p_wb_code) else $error("writeback code wrong");

    property p_load_code;
        hit_q && err_q.kind == ERR_LOAD |-> lb.code == 16'h0134;
    endproperty
    a_load_code: assert property (p_load_code) else $error("load code wrong");

    property p_fetch_code;
        hit_q && err_q.kind == ERR_FETCH |-> lb.code == 16'h0150 && !lb.code[12];
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("fetch code wrong");

    property p_flags;
        hit_q |-> lb.valid && lb.uc && lb.en && lb.s && !lb.context_corrupt_flag && !lb.over
                  && lb.ar == (err_q.kind == ERR_LOAD || err_q.kind == ERR_FETCH);
    endproperty
    a_flags: assert property (p_flags) else $error("status flags wrong");

    property p_addr_misc;
        hit_q |-> lb.addr == err_q.addr && lb.address_valid && lb.misc_info_valid
                  && lb.mode == 3'h2 && lb.lsb == err_q.lsb;
    endproperty
    a_addr_misc: assert property (p_addr_misc) else $error("address info wrong");

    // Broadcast: one all-ones cycle per logged event
    sequence s_pulse;
        machine_check_signal_o == '1;
    endsequence

    property p_broadcast;
        hit |=> s_pulse;
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast missing");

    property p_pulse_end;
        !hit |=> machine_check_signal_o == '0;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("broadcast held");

    // Nothing half written may show beside the broadcast
    property p_together;
        machine_check_signal_o != '0 |-> hit_q && lb.valid && lb.address_valid && lb.misc_info_valid;
    endproperty
    a_together: assert property (p_together) else $error("record lags broadcast");

    // Disabled logging leaves every trace alone
    property p_dropped;
        err_i.valid && !st_reg.ucr_en && !wr_i
            |=> machine_check_signal_o == '0 && $stable(st_reg.bank)
                && $stable(restart_ip_valid_o) && $stable(error_ip_valid_o);
    endproperty
    a_dropped: assert property (p_dropped) else $error("disabled event seen");

    property p_optional_action_error_gstat;
        hit_q && !req_q
            |-> restart_ip_valid_o == '1 && error_ip_valid_o == '0;
    endproperty
    a_optional_action_error_gstat: assert property (p_optional_action_error_gstat) else $error("optional flags wrong");

    property p_affected;
        hit_q && (err_q.kind == ERR_LOAD || err_q.kind == ERR_FETCH)
            |-> restart_ip_valid_o[err_q.lp] == err_q.cont
                && (!err_q.cont || error_ip_valid_o[err_q.lp]);
    endproperty
    a_affected: assert property (p_affected) else $error("affected flags wrong");

    property p_observers;
        hit_q && (err_q.kind == ERR_LOAD || err_q.kind == ERR_FETCH)
            |-> (restart_ip_valid_o | (LP_N'(1) << err_q.lp)) == '1
                && (error_ip_valid_o & ~(LP_N'(1) << err_q.lp)) == '0;
    endproperty
    a_observers: assert property (p_observers) else $error("observer flags wrong");

    property p_visible;
        hit_q |-> lp_record_o == (lp_record_o | st_reg.share[err_q.bank*LP_N +: LP_N]);
    endproperty
    a_visible: assert property (p_visible) else $error("record not visible");

    // A lone record stays out of sight of processors not sharing its bank
    property p_hidden;
        hit_q && $onehot(bank_v)
            |-> (lp_record_o & ~st_reg.share[err_q.bank*LP_N +: LP_N]) == '0;
    endproperty
    a_hidden: assert property (p_hidden) else $error("record leaked");

    property p_none;
        bank_v == '0 |-> lp_record_o == '0;
    endproperty
    a_none: assert property (p_none) else $error("record without bank");

    // The consuming processor must find its own record when it shares the bank
    property p_owner_sees;
        hit_q && req_q && st_reg.share[err_q.bank*LP_N + err_q.lp]
            |-> lp_record_o[err_q.lp];
    endproperty
    a_owner_sees: assert property (p_owner_sees) else $error("owner misses record");

    property p_not_cont;
        hit_q && req_q && !err_q.cont |-> !restart_ip_valid_o[err_q.lp];
    endproperty
    a_not_cont: assert property (p_not_cont) else $error("restart valid left set");

    // Optional-action records never ask for action
    property p_optional;
        hit_q && !req_q |-> !lb.ar && !lb.context_corrupt_flag && !lb.over && lb.valid && lb.uc && lb.en;
    endproperty
    a_optional: assert property (p_optional) else $error("optional status wrong");

    property p_filter;
        hit_q |-> !lb.code[ST_FILT] && lb.code[15:13] == 3'h0;
    endproperty
    a_filter: assert property (p_filter) else $error("filter bit set");

    property p_wb_fields;
        hit_q && err_q.kind == ERR_WRITEBACK
            |-> lb.code[3:2] == 2'h2 && lb.code[1:0] == 2'h2;
    endproperty
    a_wb_fields: assert property (p_wb_fields) else $error("wb fields wrong");

    property p_chan;
        hit_q && err_q.kind == ERR_SCRUB
            |-> lb.code[7] && lb.code[6:4] == 3'h4 && lb.code[3:0] == err_q.chan;
    endproperty
    a_chan: assert property (p_chan) else $error("memory fields wrong");

    // Software may rewrite the flags when no event competes
    property p_gstat_sw;
        wr_i && addr_i == OFF_GSTAT && !hit
            |=> restart_ip_valid_o == $past(wdata_i[LP_N-1:0])
                && error_ip_valid_o == $past(wdata_i[GSTAT_ERROR_IP_VALID_LO +: LP_N]);
    endproperty
    a_gstat_sw: assert property (p_gstat_sw) else $error("flag write lost");

    // Captured address and misc are read only
    property p_addr_hold;
        wr_i && bank_sel && sub != SUB_STATUS && !hit |=> $stable(st_reg.bank);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("record overwritten");

endmodule : rcl_logger

// ==== sim/test_rcl_logger.sv ====
// Self-checking bench for the recoverable error code logger
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module test_rcl_logger;
    import rcl_pkg::*;
    typedef struct { string nm; logic [DW-1:0] exp; } rcl_note_s;
    logic            clk_sys_i = 1'h0;
    logic            rstn_i    = 1'h0;
    rcl_err_s        err_i     = '0;
    logic [AW-1:0]   addr_i    = '0;
    logic [DW-1:0]   wdata_i   = '0;
    logic            wr_i      = 1'h0;
    logic            rd_i      = 1'h0;
    logic [DW-1:0]   rdata;
    logic [LP_N-1:0] mcs, restart_ip_valid, error_ip_valid, lp_rec;
    // Reference model of what software should see
    logic [3:0]      m_restart_ip_valid = 4'h0, m_error_ip_valid = 4'h0;
    logic [1:0]      m_bv = 2'h0;
    logic [7:0]      m_share = 8'hFF;
    logic            m_en = 1'h1;
    logic [DW-1:0]   m_addr [2];
    logic [15:0]     rnd = 16'h001B;
    rcl_note_s       rq[$], eq[$], rn, en;
    logic            rd_d = 1'h0, ev_d = 1'h0, ev_dd = 1'h0;
    int              error_cnt = 0, n_tests = 0;

    rcl_logger u_rcl_logger (
        .clk_sys_i              (clk_sys_i),
        .rstn_i                 (rstn_i),
        .err_i                  (err_i),
        .addr_i                 (addr_i),
        .wdata_i                (wdata_i),
        .wr_i                   (wr_i),
        .rd_i                   (rd_i),
        .rdata_o                (rdata),
        .machine_check_signal_o (mcs),
        .restart_ip_valid_o     (restart_ip_valid),
        .error_ip_valid_o       (error_ip_valid),
        .lp_record_o            (lp_rec)
    );

    always #50 clk_sys_i = ~clk_sys_i;

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    function automatic logic [AW-1:0] ba(input int b, input logic [3:0] sub);
        return {SLOT_FIRST + 4'(b), sub};
    endfunction : ba

    function automatic logic [15:0] code_of(input rcl_kind_e k, input logic [3:0] ch);
        case (k)
            ERR_SCRUB:     return {8'h00, 1'h1, 3'h4, ch};
            ERR_WRITEBACK: return 16'h017A;
            ERR_LOAD:      return 16'h0134;
            default:       return 16'h0150;
        endcase
    endfunction : code_of

    function automatic logic [3:0] rec_of(input logic [7:0] sh, input logic [1:0] bv);
        return (sh[3:0] & {4{bv[0]}}) | (sh[7:4] & {4{bv[1]}});
    endfunction : rec_of

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'h1;
        @(posedge clk_sys_i);
        wr_i    <= 1'h0;
    endtask : wr

    task automatic rd(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
        rq.push_back('{nm, e});
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'h1;
        @(posedge clk_sys_i);
        rd_i   <= 1'h0;
    endtask : rd

    task automatic ev(input rcl_kind_e k, input logic [3:0] ch, input int b,
                      input logic [1:0] lp, input logic cont, input logic enc);
        rcl_err_s e;
        logic     ar;
        rnd = lfsr_next(rnd);
        e = '0;
        e.valid = 1'h1;
        e.kind = k;
        e.chan = ch;
        e.addr = {rnd, ~rnd};
        e.lsb = {1'h0, rnd[4:0]};
        e.bank = b[0];
        e.lp = lp;
        e.cont = cont;
        e.error_ip_valid_nc = enc;
        ar = (k == ERR_LOAD) || (k == ERR_FETCH);
        // Disabled logging must leave every trace untouched
        if (m_en) begin
            m_restart_ip_valid = 4'hF;
            m_error_ip_valid = 4'h0;
            if (ar) begin
                m_restart_ip_valid[lp] = cont;
                m_error_ip_valid[lp] = cont | enc;
            end
            m_bv[b] = 1'h1;
            m_addr[b] = e.addr;
        end
        eq.push_back('{"event", {16'h0, m_en ? 4'hF : 4'h0, m_restart_ip_valid, m_error_ip_valid,
                      rec_of(m_share, m_bv)}});
        @(posedge clk_sys_i);
        err_i <= e;
        @(posedge clk_sys_i);
        err_i <= '0;
        if (m_en) begin
            rd("status", ba(b, SUB_STATUS), {8'hBD, ar, 7'h00, code_of(k, ch)});
            rd("address", ba(b, SUB_ADDR), e.addr);
            rd("misc", ba(b, SUB_MISC), {23'h0, 3'h2, e.lsb});
        end
        rd("global status", OFF_GSTAT, {24'h0, m_error_ip_valid, m_restart_ip_valid});
    endtask : ev

    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    always @(posedge clk_sys_i) begin
        rd_d  <= rd_i;
        ev_d  <= err_i.valid;
        ev_dd <= ev_d;
    end

    // Results are settled by the falling edge
    always @(negedge clk_sys_i) begin
        if (rd_d) begin
            rn = rq.pop_front();
            `CHK(rn.nm, rn.exp, rdata)
        end
        if (ev_d) begin
            en = eq.pop_front();
            `CHK("broadcast", en.exp[15:12], mcs)
            `CHK("restart valid", en.exp[11:8], restart_ip_valid)
            `CHK("error ip valid", en.exp[7:4], error_ip_valid)
            `CHK("record seen", en.exp[3:0], lp_rec)
        end
        if (ev_dd && !ev_d)
            `CHK("broadcast end", 4'h0, mcs)
    end

    initial begin
        #(100 * 3000);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'h1;
        rd("ctrl reset", OFF_CTRL, 32'h0000_0001);
        rd("share reset", OFF_SHARE, 32'h0000_00FF);
        rd("gstat reset", OFF_GSTAT, 32'h0000_0000);
        rd("status reset", ba(0, SUB_STATUS), 32'h0000_0000);
        rd("unmapped", 8'hFC, 32'h0000_0000);
        // Every kind into both banks, continuable and not
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            ev(rcl_kind_e'(i[1:0]), (i == 0) ? 4'hF : rnd[3:0], i / 4, rnd[7:6],
               i[2], rnd[8]);
        end
        wr(ba(1, SUB_ADDR), 32'hFFFF_FFFF);
        rd("address read only", ba(1, SUB_ADDR), m_addr[1]);
        // Bank 0 private to cpu 0, bank 1 to cpu 2
        wr(OFF_SHARE, 32'h0000_0041);
        m_share = 8'h41;
        wr(ba(0, SUB_STATUS), 32'h0000_0000);
        wr(ba(1, SUB_STATUS), 32'h0000_0000);
        m_bv = 2'h0;
        rd("status cleared", ba(1, SUB_STATUS), 32'h0000_0000);
        ev(ERR_LOAD, 4'h0, 1, 2'h2, 1'h1, 1'h0);
        ev(ERR_FETCH, 4'h0, 0, 2'h0, 1'h0, 1'h1);
        wr(OFF_GSTAT, 32'h0000_00A5);
        m_restart_ip_valid = 4'h5;
        m_error_ip_valid = 4'hA;
        rd("gstat written", OFF_GSTAT, 32'h0000_00A5);
        // Logging switched off drops the event wholly
        wr(OFF_CTRL, 32'h0000_0000);
        m_en = 1'h0;
        ev(ERR_SCRUB, 4'h3, 0, 2'h0, 1'h0, 1'h0);
        rd("status kept", ba(0, SUB_STATUS), 32'hBD80_0150);
        wr(OFF_CTRL, 32'h0000_0001);
        m_en = 1'h1;
        ev(ERR_WRITEBACK, 4'h0, 0, 2'h1, 1'h0, 1'h0);
        repeat (2) @(posedge clk_sys_i);
        stop_test();
    end
endmodule : test_rcl_logger
